// ---- inc/chc_pkg.sv ----
// Constants shared by the channel power, calibration and sync control block
// Notes on behaviour
// - A 0-to-1 write of the calibrate bit arms a calibration run on the next update strobe.
// - Hardware never clears the calibrate bit; it keeps its written value after calibration.
// - Channel power-down at bit 0 powers the channel down and tristates all its outputs.
// - While sync-all at bit 3 is 1, drivers are held static and dividers held in reset.
// - In the sync state differential drivers sit muted, not tristated.
// - Releasing sync-all from 1 to 0 restarts all dividers together and aligned; here a divider still held by a power-down or reset bit stays stopped.
// - Each per-output power-down bit tristates its own output driver pair.
// - Mute-all holds the positive leg static low and the complementary leg static high.
package chc_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PWR_CAL = 14'h2100;
  localparam logic [13:0] IDX_GLOBAL = 14'h2101;
  localparam logic [13:0] IDX_DIV0 = 14'h2102;
  localparam logic [13:0] IDX_DIV1 = 14'h2103;
  localparam logic [13:0] IDX_DIV2 = 14'h2104;
  localparam logic [13:0] IDX_UPDATE = 14'h2110;
  localparam logic [13:0] IDX_STATUS = 14'h2111;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PC_PD = 0;
  localparam int PC_CAL = 1;
  localparam int GL_MUTE = 1;
  localparam int GL_DRST = 2;
  localparam int GL_SYNC = 3;
  localparam int DV_RST_P = 0;
  localparam int DV_RST_N = 1;
  localparam int DV_MUTE_P = 2;
  localparam int DV_MUTE_N = 3;
  localparam int DV_PD = 4;
  localparam int DV_DRST = 5;
  localparam int UP_STROBE = 0;
  localparam int ST_ARMED = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_DONE = 2;
  // ----------------------------------------------------------------
  // Reset values, bus answers and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PWR_CAL_RST = 2'h0;
  localparam logic [2:0] GLOBAL_RST = 3'h0;
  localparam logic [5:0] DIV_RST = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_OUT = 3;
  localparam int CAL_CYCLES_DEF = 64;
  localparam int DIV_HALF_DEF = 2;
endpackage

// ---- inc/chc_ctrl_if.sv ----
// Control and pin signals between the register side and the output stage
`timescale 1ns/10ps
interface chc_ctrl_if;
  import chc_pkg::*;
  logic chan_pd;
  logic sync_all;
  logic mute_all;
  logic drv_rst_all;
  logic [5:0] out_ctrl [NUM_OUT];
  logic [NUM_OUT-1:0] pin_p;
  logic [NUM_OUT-1:0] pin_n;
  logic [NUM_OUT-1:0] pin_oe_n;
  logic [NUM_OUT-1:0] div_run;
  modport ctl (output chan_pd, sync_all, mute_all, drv_rst_all, out_ctrl,
               input pin_p, pin_n, pin_oe_n, div_run);
  modport stage (input chan_pd, sync_all, mute_all, drv_rst_all, out_ctrl,
                 output pin_p, pin_n, pin_oe_n, div_run);
endinterface

// ---- hw/chc_output_stage.sv ----
// Output dividers and driver pair control for the channel outputs
`timescale 1ns/10ps
module chc_output_stage import chc_pkg::*; #(
  parameter int DIV_HALF = DIV_HALF_DEF
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  chc_ctrl_if.stage ctl
);
  logic [7:0] div_cnt_r [NUM_OUT];
  logic [NUM_OUT-1:0] div_q_r;

  // ----------------------------------------------------------------
  // Per-output divider and driver
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    logic pd_i;
    logic hold_i;
    logic static_i;
    assign pd_i = ctl.chan_pd | ctl.out_ctrl[i][DV_PD];
    assign hold_i = pd_i | ctl.sync_all | ctl.out_ctrl[i][DV_RST_P] | ctl.out_ctrl[i][DV_RST_N];
    assign static_i = ctl.sync_all | ctl.mute_all | ctl.drv_rst_all
                      | ctl.out_ctrl[i][DV_DRST] | ctl.out_ctrl[i][DV_MUTE_P];

    // Divider counts from zero after any hold, so common release aligns outputs
    // aligned restart
    always_ff @(posedge mclk_in) begin
      if (reset_in || hold_i) begin
        div_cnt_r[i] <= 8'h00;
        div_q_r[i] <= 1'b0;
      end else if (div_cnt_r[i] == 8'(DIV_HALF - 1)) begin
        div_cnt_r[i] <= 8'h00;
        div_q_r[i] <= ~div_q_r[i];
      end else begin
        div_cnt_r[i] <= div_cnt_r[i] + 8'h01;
      end
    end

    // Pin levels registered so the top sees flip-flop outputs
    always_ff @(posedge mclk_in) begin
      if (reset_in) begin
        ctl.pin_p[i] <= 1'b0;
        ctl.pin_n[i] <= 1'b1;
        ctl.pin_oe_n[i] <= 1'b1;
        ctl.div_run[i] <= 1'b0;
      end else begin
        ctl.pin_oe_n[i] <= pd_i;
        ctl.div_run[i] <= ~hold_i;
        ctl.pin_p[i] <= static_i ? 1'b0 : div_q_r[i];
        ctl.pin_n[i] <= static_i ? 1'b1 : (ctl.out_ctrl[i][DV_MUTE_N] ? 1'b0 : ~div_q_r[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sync_static_a: assert property (ctl.sync_all |=> ctl.pin_p == '0 && ctl.pin_n == '1)
    else $error("sync state did not mute the drivers");
  sync_hold_a: assert property (ctl.sync_all |=> ctl.div_run == '0)
    else $error("divider ran during sync");
  chan_pd_a: assert property (ctl.chan_pd |=> ctl.pin_oe_n == '1)
    else $error("powered-down channel still drives");
  out_pd_a: assert property (ctl.out_ctrl[0][DV_PD] |=> ctl.pin_oe_n[0])
    else $error("output power-down did not tristate");
  sync_align_a: assert property ($fell(ctl.sync_all) && !ctl.chan_pd
      && ctl.out_ctrl[0] == '0 && ctl.out_ctrl[1] == '0 && ctl.out_ctrl[2] == '0
      |-> div_cnt_r[0] == 8'h00 && div_cnt_r[1] == 8'h00 && div_cnt_r[2] == 8'h00)
    else $error("dividers not aligned at sync release");
  mute_legs_a: assert property (ctl.mute_all && !ctl.sync_all
      |=> ctl.pin_p == '0 && ctl.pin_n == '1)
    else $error("mute-all legs wrong");
endmodule

// ---- hw/chc_channel_ctrl.sv ----
// Channel power, oscillator calibration and divider sync control with AXI4-Lite registers
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module chc_channel_ctrl import chc_pkg::*; #(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF,
  parameter int DIV_HALF = DIV_HALF_DEF
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [15:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [15:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic [NUM_OUT-1:0] out_p_out,
  output logic [NUM_OUT-1:0] out_n_out,
  output logic [NUM_OUT-1:0] out_oe_n_out,
  output logic [NUM_OUT-1:0] div_run_out,
  output logic chan_pd_out,
  output logic cal_run_out,
  output logic cal_busy_out
);
  chc_ctrl_if cif ();

  logic aw_held_r;
  logic w_held_r;
  logic [13:0] waddr_r;
  logic [31:0] wdata_r;
  logic wlane_r;
  logic do_write;
  logic wr_hit;
  logic [1:0] pwr_cal_r;
  logic [2:0] global_r;
  logic [5:0] div_ctrl_r [NUM_OUT];
  logic cal_armed_r;
  logic cal_done_r;
  logic [15:0] cal_cnt_r;
  logic cal_start;
  logic wr_pc;

  // ----------------------------------------------------------------
  // Register map decode
  // ----------------------------------------------------------------
  function automatic logic idx_valid(input logic [13:0] idx);
    idx_valid = (idx == IDX_PWR_CAL) || (idx == IDX_GLOBAL) || (idx == IDX_DIV0)
                || (idx == IDX_DIV1) || (idx == IDX_DIV2) || (idx == IDX_UPDATE)
                || (idx == IDX_STATUS);
  endfunction

  // Unused register bits stay zero on read
  // reserved read zero
  function automatic logic [31:0] read_mux(input logic [13:0] idx);
    read_mux = 32'h0000_0000;
    unique case (idx)
      IDX_PWR_CAL: read_mux[1:0] = pwr_cal_r;
      IDX_GLOBAL: read_mux[3:1] = global_r;
      IDX_DIV0: read_mux[5:0] = div_ctrl_r[0];
      IDX_DIV1: read_mux[5:0] = div_ctrl_r[1];
      IDX_DIV2: read_mux[5:0] = div_ctrl_r[2];
      IDX_STATUS: begin
        read_mux[ST_ARMED] = cal_armed_r;
        read_mux[ST_BUSY] = cal_busy_out;
        read_mux[ST_DONE] = cal_done_r;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Address and data are latched separately, so either may arrive first
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      aw_held_r <= 1'b0;
      s_axi_awready_out <= 1'b0;
      waddr_r <= 14'h0000;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_r <= 1'b1;
      s_axi_awready_out <= 1'b0;
      waddr_r <= s_axi_awaddr_in[15:2];
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      aw_held_r <= 1'b0;
      s_axi_awready_out <= 1'b1;
    end else if (!aw_held_r && !s_axi_bvalid_out) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      w_held_r <= 1'b0;
      s_axi_wready_out <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wlane_r <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_r <= 1'b1;
      s_axi_wready_out <= 1'b0;
      wdata_r <= s_axi_wdata_in;
      wlane_r <= s_axi_wstrb_in[0];
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      w_held_r <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end else if (!w_held_r && !s_axi_bvalid_out) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  // Register update happens once, in the cycle both halves are present
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid_out;
  assign wr_hit = do_write && wlane_r;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= idx_valid(waddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= read_mux(s_axi_araddr_in[15:2]);
      s_axi_rresp_out <= idx_valid(s_axi_araddr_in[15:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end else if (!s_axi_rvalid_out) begin
      s_axi_arready_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign wr_pc = wr_hit && (waddr_r == IDX_PWR_CAL);

  // Only the defined bits are stored; the rest of each byte is dropped
  // software-owned bits
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pwr_cal_r <= PWR_CAL_RST;
      global_r <= GLOBAL_RST;
    end else begin
      if (wr_pc) begin
        pwr_cal_r <= wdata_r[1:0];
      end
      if (wr_hit && waddr_r == IDX_GLOBAL) begin
        global_r <= wdata_r[3:1];
      end
    end
  end

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_div
    always_ff @(posedge mclk_in) begin
      if (reset_in) begin
        div_ctrl_r[i] <= DIV_RST;
      end else if (wr_hit && waddr_r == IDX_DIV0 + 14'(i)) begin
        div_ctrl_r[i] <= wdata_r[5:0];
      end
    end
    assign cif.out_ctrl[i] = div_ctrl_r[i];
  end

  // ----------------------------------------------------------------
  // Oscillator calibration
  // ----------------------------------------------------------------
  // A rising write of the calibrate bit arms; the update strobe starts it
  // arm and start
  assign cal_start = cal_armed_r && wr_hit && (waddr_r == IDX_UPDATE) && wdata_r[UP_STROBE];

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cal_armed_r <= 1'b0;
    end else if (wr_pc && wdata_r[PC_CAL] && !pwr_cal_r[PC_CAL]) begin
      cal_armed_r <= 1'b1;
    end else if (cal_start) begin
      cal_armed_r <= 1'b0;
    end
  end

  // Busy counts a fixed time; a strobe during a run is ignored as nothing is armed
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cal_run_out <= 1'b0;
      cal_busy_out <= 1'b0;
      cal_done_r <= 1'b0;
      cal_cnt_r <= 16'h0000;
    end else begin
      cal_run_out <= cal_start;
      if (cal_start) begin
        cal_busy_out <= 1'b1;
        cal_done_r <= 1'b0;
        cal_cnt_r <= 16'(CAL_CYCLES - 1);
      end else if (cal_busy_out && cal_cnt_r == 16'h0000) begin
        cal_busy_out <= 1'b0;
        cal_done_r <= 1'b1;
      end else if (cal_busy_out) begin
        cal_cnt_r <= cal_cnt_r - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // channel-wide controls
  assign cif.chan_pd = pwr_cal_r[PC_PD];
  assign cif.sync_all = global_r[GL_SYNC - 1];
  assign cif.mute_all = global_r[GL_MUTE - 1];
  assign cif.drv_rst_all = global_r[GL_DRST - 1];

  chc_output_stage #(.DIV_HALF(DIV_HALF)) u_stage (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .ctl(cif.stage)
  );

  assign out_p_out = cif.pin_p;
  assign out_n_out = cif.pin_n;
  assign out_oe_n_out = cif.pin_oe_n;
  assign div_run_out = cif.div_run;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      chan_pd_out <= 1'b0;
    end else begin
      chan_pd_out <= pwr_cal_r[PC_PD];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence cal_arm_s;
    wr_pc && wdata_r[PC_CAL] && !pwr_cal_r[PC_CAL];
  endsequence

  cal_arm_a: assert property (cal_arm_s |=> cal_armed_r && pwr_cal_r[PC_CAL])
    else $error("calibration not armed on rising write");
  cal_start_a: assert property (cal_start
      |=> cal_run_out && cal_busy_out && !cal_armed_r)
    else $error("calibration did not start on update strobe");
  cal_keep_a: assert property ($fell(cal_busy_out) |-> pwr_cal_r == $past(pwr_cal_r))
    else $error("calibrate bit changed by hardware");
  cal_noarm_a: assert property (!cal_armed_r && !cal_busy_out ##1 !cal_armed_r
      |-> !cal_busy_out)
    else $error("calibration ran without arming");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
      && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
      && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  resv_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:6] == 26'h0)
    else $error("reserved bits read nonzero");
  sync_path_a: assert property (wr_hit && waddr_r == IDX_GLOBAL && wdata_r[GL_SYNC]
      |=> ##1 div_run_out == '0)
    else $error("sync write did not stop dividers");
endmodule

// ---- bench/tb_top.sv ----
// Self-checking testbench for the channel power, calibration and sync control block
`timescale 1ns/10ps
module tb_top;
  import chc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int CALN = 6;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [NUM_OUT-1:0] out_p, out_n, out_oe_n, div_run;
  logic chan_pd, cal_run, cal_busy;
  int bad_count = 0;
  int checks = 0;
  int run_cnt = 0;
  int tog;
  integer seed = 32'hff30;

  // Free-running bench clock, 4 ns period
  always #2 mclk_in = ~mclk_in;

  chc_channel_ctrl #(.CAL_CYCLES(CALN), .DIV_HALF(2)) u_chc_channel_ctrl (
    .mclk_in(mclk_in), .reset_in(reset_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .out_p_out(out_p), .out_n_out(out_n),
    .out_oe_n_out(out_oe_n), .div_run_out(div_run), .chan_pd_out(chan_pd),
    .cal_run_out(cal_run), .cal_busy_out(cal_busy));

  // Count calibration start pulses; a stuck-high pulse shows up as an extra count
  always @(posedge mclk_in) begin
    if (cal_run === 1'b1) run_cnt++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Write with both channels offered together, each released once taken
  // Response ready stays high between calls, so it never drops and rises in one step
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rsp = bresp;
  endtask

  // Only the watchdog ends a wait that never sees the answer
  task automatic rd(input logic [15:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rv = rdata;
    rsp = rresp;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    check(rv, exp);
  endtask

  // Pins settle one edge after the register; mask hides the toggling legs
  task automatic pins(input logic [11:0] exp, input logic [11:0] m);
    repeat (2) @(posedge mclk_in);
    check({out_p, out_n, out_oe_n, div_run} & m, exp);
  endtask

  // Update strobe, then count busy cycles: a full run when armed, none otherwise
  task automatic strobe_wait(input logic armed);
    int n;
    wr(16'h8440, 32'h1);
    n = 0;
    while (cal_busy !== 1'b0) begin
      @(posedge mclk_in);
      n++;
    end
    check(n, armed ? CALN : 0);
  endtask

  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rd_chk(16'h8400, 32'h0);
    rd_chk(16'h8404, 32'h0);
    pins(12'h007, 12'h03f);
    // strobe alone starts nothing, a 0-to-1 arms one run
    strobe_wait(1'b0);
    check(run_cnt, 0);
    // calibrate once at setup, outputs already configured
    wr(16'h8400, 32'hffff_fffe);
    rd_chk(16'h8400, 32'h2);
    rd_chk(16'h8444, 32'h1);
    strobe_wait(1'b1);
    check(run_cnt, 1);
    rd_chk(16'h8444, 32'h4);
    // bit kept after calibration; rewriting 1 does not re-arm
    rd_chk(16'h8400, 32'h2);
    wr(16'h8400, 32'h2);
    strobe_wait(1'b0);
    check(run_cnt, 1);
    wr(16'h8400, 32'h0);
    wr(16'h8400, 32'h2);
    strobe_wait(1'b1);
    check(run_cnt, 2);
    // A write with the low strobe clear stores nothing
    wr(16'h8400, 32'h1, 4'h0);
    rd_chk(16'h8400, 32'h2);
    wr(16'h8400, 32'h0);
    wr(16'h8400, 32'h1);
    pins(12'h038, 12'h038);
    check(chan_pd, 1);
    wr(16'h8400, 32'h0);
    pins(12'h007, 12'h03f);
    // sync holds drivers static and dividers reset, muted not tristated
    wr(16'h8404, 32'h8);
    pins(12'h1c0, 12'hfff);
    rd_chk(16'h8404, 32'h8);
    wr(16'h8404, 32'h0);
    repeat (2) @(posedge mclk_in);
    tog = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_in);
      check({div_run, out_p}, {3'h7, {3{out_p[0]}}});
      if (out_p[0] === 1'b1) tog++;
    end
    // Half period of 2 gives a 4-cycle period, so any 8 samples hold 4 highs
    check(tog, 4);
    // mute-all: p low, n high, still driven, dividers keep running
    wr(16'h8404, 32'h2);
    pins(12'h1c7, 12'hfff);
    wr(16'h8404, 32'h0);
    // per-output power-down tristates only its own pair
    for (int i = 0; i < NUM_OUT; i++) begin
      wr(16'h8408 + 16'(4 * i), 32'h10);
      pins(12'(1 << (i + 3)), 12'h038);
      wr(16'h8408 + 16'(4 * i), 32'h0);
    end
    // random writes: reserved bits and the unstored bit read 0
    for (int k = 0; k < 8; k++) begin
      d = $random(seed);
      wr(16'h8400, d);
      rd_chk(16'h8400, d & 32'h3);
      d = $random(seed);
      wr(16'h8404, d);
      rd_chk(16'h8404, d & 32'he);
    end
    wr(16'h8400, 32'h0);
    check(rsp, RESP_OKAY);
    wr(16'h8404, 32'h0);
    // Unmapped address answers an error and reads zero
    wr(16'h8200, 32'hff);
    check(rsp, RESP_SLVERR);
    rd_chk(16'h8200, 32'h0);
    check(rsp, RESP_SLVERR);
    pins(12'h007, 12'h03f);
    complete_run();
  end
endmodule
